// File: src/lcdmdc_drive_top.sv
// Function
// (RULE1) Supply bit enables drive, off grounds all
// (RULE2) Software waits about 100 ms after power-on
// (RULE3) Reference bit picks mid or low level
// (RULE4) Mid reference only at 2.6 V or more
// (RULE5) Duty bits pick 1/8, 1/16 or 1/17
// (RULE6) All-lit drives lit segments, memory untouched
// (RULE7) All-dark drives unlit segments, memory untouched
// (RULE8) All-lit wins over all-dark
// (RULE9) Page bit picks shown half at 1/8
// (RULE10) Page bit is plain storage otherwise
// (RULE11) Contrast code 0 light, 15 dark
// (RULE12) Software uses contrast 7 or 8 typically
// (RULE13) External supply ignores contrast and reference
// (RULE14) Contrast and memory have no reset value
// (RULE15) Reset clears controls, sets all-dark
// (RULE16) Software initialises memory and contrast first
// (RULE17) Software avoids unpopulated memory holes
// (RULE18) Memory one lights dot, zero leaves dark
// (RULE19) Display memory is read/write storage
// (RULE20) Frame 32 Hz, or 30.12 Hz at 1/17
// (RULE21) Commons scanned ascending, row on segments
//
// Our own choice: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module lcdmdc_drive_top #(
   parameter int SEG_N      = 40,
   parameter bit EXT_SUPPLY = 1'b0
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [17:0]      wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic [31:0]           wb_dat_o,
   output logic                  wb_ack_o,
   // Low-speed oscillator pin
   input  wire logic             osc_lo_i,
   // Panel drive
   output logic [16:0]           com_o,
   output logic [SEG_N-1:0]      seg_o,
   output logic                  frame_phase_o,
   // Drive-voltage generator control
   output logic                  supply_on_o,
   output logic                  ref_mid_o,
   output logic [3:0]            contrast_o
);

   // ****************************************
   // Elaboration checks
   // ****************************************

   // Memory map holds at most forty segments
   if (SEG_N < 1 || SEG_N > lcdmdc_pkg::SEG_MAX) begin : g_bad_seg
      $error("SEG_N out of range");
   end

   // Slot periods must fit the seven-bit slot divider
   if (lcdmdc_pkg::SLOT_SRC_8 < 1 || lcdmdc_pkg::SLOT_SRC_8 > 128
       || lcdmdc_pkg::SLOT_SRC_16 < 1 || lcdmdc_pkg::SLOT_SRC_16 > 128) begin : g_bad_slot
      $error("slot period does not fit the divider");
   end

   // Common bus is fixed at seventeen lines
   if (lcdmdc_pkg::COM_MAX != 17) begin : g_bad_com
      $error("COM_MAX must match the common bus");
   end

   // ****************************************
   // Declarations
   // ****************************************

   lcdmdc_pkg::lcdmdc_ctrl_t ctrl_q;
   logic [3:0]               contr_q;
   logic [15:0]              idx;
   logic [2:0]               rsel;
   logic                     req;
   logic                     wr_go;
   logic                     lane0;
   logic [8:0]               mslot;
   logic                     mem_we;
   logic [3:0]               mem_rdat;
   logic [4:0]               com_idx;
   logic                     phase;
   logic [4:0]               row;
   logic [SEG_N-1:0]         row_bits;
   logic [SEG_N-1:0]         seg_d;
   logic [16:0]              com_d;
   logic [31:0]              rdat_d;

   // ****************************************
   // Functions
   // ****************************************

   // Map a word index onto a memory slot, bit 8 is the hit flag
   function automatic logic [8:0] mem_slot(input logic [15:0] i);
      logic [8:0] r;
      r = 9'h000;
      if (i[15:8] == lcdmdc_pkg::MEM_PAGE0
          && i[7:0] < lcdmdc_pkg::MEM_PAGE_LEN) begin
         r = {1'b1, i[7:0]};
      end else if (i[15:8] == lcdmdc_pkg::MEM_PAGE1
                   && i[7:0] < lcdmdc_pkg::MEM_PAGE_LEN) begin
         r = {1'b1, lcdmdc_pkg::SLOT_PAGE1 + i[7:0]};
      end else if (i[15:8] == lcdmdc_pkg::MEM_ROW16
                   && i[7:0] <= lcdmdc_pkg::MEM_ROW16_END
                   && !i[0]) begin
         r = {1'b1, lcdmdc_pkg::SLOT_ROW16 + {1'b0, i[7:1]}};
      end
      return r;
   endfunction

   // Segment level for one dot under the overrides
   function automatic logic dot_level(input logic mem_bit,
                                      input logic lit,
                                      input logic dark);
      logic r;
      r = mem_bit;
      if (lit) begin
         r = 1'b1;
      end else if (dark) begin
         r = 1'b0;
      end
      return r;
   endfunction

   // Control word select: bit 0 drive, bit 1 display, bit 2 contrast
   function automatic logic [2:0] reg_sel(input logic [15:0] i);
      logic [2:0] r;
      r    = 3'h0;
      r[0] = (i == lcdmdc_pkg::IDX_DRIVE);
      r[1] = (i == lcdmdc_pkg::IDX_DISP);
      r[2] = (i == lcdmdc_pkg::IDX_CONTR);
      return r;
   endfunction

   // ****************************************
   // Bus decode
   // ****************************************

   // Word index from the byte address
   assign idx   = wb_adr_i[17:2];
   assign req   = wb_cyc_i & wb_stb_i;
   assign lane0 = wb_sel_i[0];

   // Writes land on the edge where ack is seen
   assign wr_go = req & wb_we_i & wb_ack_o & lane0;

   // Memory slot, shared by read and write
   assign mslot  = mem_slot(idx);
   assign mem_we = wr_go & mslot[8];
   assign rsel   = reg_sel(idx);

   // ****************************************
   // Wishbone acknowledge
   // ****************************************

   // One-cycle ack, one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
      end
   end

   // ****************************************
   // Control registers
   // ****************************************

   // Drive nibble and display nibble
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= lcdmdc_pkg::CTRL_RST; // RULE15
      end else if (wr_go && rsel[0]) begin
         ctrl_q.supply_on <= wb_dat_i[0]; // RULE1
         ctrl_q.ref_mid   <= wb_dat_i[1]; // RULE3
         ctrl_q.duty      <= wb_dat_i[3:2]; // RULE5
      end else if (wr_go && rsel[1]) begin
         ctrl_q.page      <= wb_dat_i[0]; // RULE10
         ctrl_q.all_lit   <= wb_dat_i[1]; // RULE6
         ctrl_q.all_dark  <= wb_dat_i[2]; // RULE7
         ctrl_q.spare     <= wb_dat_i[3];
      end
   end

   // Contrast code, deliberately outside the reset
   always_ff @(posedge clk_i) begin
      if (wr_go && rsel[2]) begin
         contr_q <= wb_dat_i[3:0]; // RULE14
      end
   end

   // ****************************************
   // Read data
   // ****************************************

   // Read mux, unmapped words read zero
   always_comb begin
      rdat_d = 32'h0000_0000;
      if (mslot[8]) begin
         rdat_d[3:0] = mem_rdat; // RULE19
      end else begin
         unique case (idx)
            lcdmdc_pkg::IDX_DRIVE: begin
               rdat_d[3:0] = ctrl_q[lcdmdc_pkg::DRV_LSB +: 4];
            end
            lcdmdc_pkg::IDX_DISP: begin
               rdat_d[3:0] = ctrl_q[lcdmdc_pkg::DSP_LSB +: 4];
            end
            lcdmdc_pkg::IDX_CONTR: begin
               rdat_d[3:0] = contr_q;
            end
            lcdmdc_pkg::IDX_STATUS: begin
               rdat_d[5:0] = {phase, com_idx};
            end
            default: begin
               rdat_d = 32'h0000_0000;
            end
         endcase
      end
   end

   // Read data registered alongside ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && !wb_ack_o) begin
         wb_dat_o <= rdat_d;
      end
   end

   // ****************************************
   // Display memory
   // ****************************************

   // Storage and row readout
   lcdmdc_disp_mem #(
      .SEG_N (SEG_N)
   ) u_mem (
      .clk_i   (clk_i),
      .we_i    (mem_we),
      .wslot_i (mslot[7:0]),
      .wdat_i  (wb_dat_i[3:0]),
      .rslot_i (mslot[7:0]),
      .rdat_o  (mem_rdat),
      .row_i   (row),
      .row_o   (row_bits)
   );

   // ****************************************
   // Scan timing
   // ****************************************

   // Slot and frame sequencing from the low-speed oscillator
   lcdmdc_scan_timer u_timer (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .osc_lo_i  (osc_lo_i),
      .duty_i    (ctrl_q.duty),
      .com_idx_o (com_idx),
      .phase_o   (phase)
   );

   // ****************************************
   // Row selection
   // ****************************************

   // At 1/8 the page bit moves the scan to the second half
   always_comb begin
      row = com_idx;
      if (ctrl_q.duty[1]) begin
         row = {1'b0, ctrl_q.page, com_idx[2:0]}; // RULE9
      end
   end

   // ****************************************
   // Segment and common drive
   // ****************************************

   // Overrides applied per dot, memory left alone
   always_comb begin
      seg_d = '0;
      for (int s = 0; s < SEG_N; s++) begin
         seg_d[s] = dot_level(row_bits[s], ctrl_q.all_lit,
                              ctrl_q.all_dark); // RULE8
      end
   end

   // One active common per slot
   always_comb begin
      com_d = '0;
      com_d[com_idx] = 1'b1; // RULE21
   end

   // Panel outputs, all grounded while supply is off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seg_o         <= '0;
         com_o         <= '0;
         frame_phase_o <= 1'b0;
      end else if (!ctrl_q.supply_on) begin
         seg_o         <= '0; // RULE1
         com_o         <= '0; // RULE1
         frame_phase_o <= 1'b0;
      end else begin
         seg_o         <= seg_d; // RULE18
         com_o         <= com_d;
         frame_phase_o <= phase;
      end
   end

   // ****************************************
   // Drive-voltage generator control
   // ****************************************

   // Supply enable straight from its control bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         supply_on_o <= 1'b0;
      end else begin
         supply_on_o <= ctrl_q.supply_on; // RULE1
      end
   end

   // Reference and contrast, held at zero for external supply
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_mid_o  <= 1'b0;
         contrast_o <= 4'h0;
      end else if (EXT_SUPPLY || !ctrl_q.supply_on) begin
         ref_mid_o  <= 1'b0; // RULE13
         contrast_o <= 4'h0; // RULE13
      end else begin
         ref_mid_o  <= ctrl_q.ref_mid; // RULE3
         contrast_o <= contr_q; // RULE11
      end
   end

endmodule
`default_nettype wire

// File: src/lcdmdc_pkg.sv
package lcdmdc_pkg;

   // ****************************************
   // Bus geometry
   // ****************************************
   localparam int          ADR_W = 18;
   localparam int          IDX_W = 16;

   // Register word indices, byte address is four times these
   localparam logic [15:0] IDX_DRIVE  = 16'hff60;
   localparam logic [15:0] IDX_DISP   = 16'hff61;
   localparam logic [15:0] IDX_CONTR  = 16'hff62;
   localparam logic [15:0] IDX_STATUS = 16'hff63;

   // Display memory word indices
   localparam logic [7:0]  MEM_PAGE0 = 8'hf0;
   localparam logic [7:0]  MEM_PAGE1 = 8'hf1;
   localparam logic [7:0]  MEM_ROW16 = 8'hf2;
   localparam logic [7:0]  MEM_PAGE_LEN  = 8'h50;
   localparam logic [7:0]  MEM_ROW16_END = 8'h4e;
   localparam logic [7:0]  SLOT_PAGE1 = 8'h50;
   localparam logic [7:0]  SLOT_ROW16 = 8'ha0;
   localparam int          MEM_WORDS = 200;

   // ****************************************
   // Panel geometry and frame timing
   // ****************************************
   localparam int          SEG_MAX = 40;
   localparam int          COM_MAX = 17;
   localparam int          SRC_HZ   = 32768;
   localparam int          FRAME_HZ = 32;
   localparam int          SLOT_SRC_16 = SRC_HZ / (FRAME_HZ * 16);
   localparam int          SLOT_SRC_8  = SRC_HZ / (FRAME_HZ * 8);
   localparam logic [4:0]  LAST_COM_8  = 5'h07;
   localparam logic [4:0]  LAST_COM_16 = 5'h0f;
   localparam logic [4:0]  LAST_COM_17 = 5'h10;

   // ****************************************
   // Control state, both control nibbles
   // ****************************************
   typedef struct packed {
      logic       spare;
      logic       all_dark;
      logic       all_lit;
      logic       page;
      logic [1:0] duty;
      logic       ref_mid;
      logic       supply_on;
   } lcdmdc_ctrl_t;

   localparam int          DRV_LSB = 0;
   localparam int          DSP_LSB = 4;
   localparam logic [7:0]  CTRL_RST = 8'h40;

endpackage

// File: src/lcdmdc_scan_timer.sv
`timescale 1ns/100ps
`default_nettype none
module lcdmdc_scan_timer (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Low-speed oscillator pin and duty
   input  wire logic       osc_lo_i,
   input  wire logic [1:0] duty_i,
   // Scan position
   output logic [4:0]      com_idx_o,
   output logic            phase_o
);

   logic       s1_q, s2_q, s3_q, lvl_q;
   logic [6:0] div_q;
   logic       tick;
   logic [6:0] per;
   logic [4:0] last;

   // Three-stage pin synchroniser
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= osc_lo_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Accept a level once stages two and three agree
   always_ff @(posedge clk_i) begin
      if (rst_i) lvl_q <= 1'b0;
      else if (s2_q == s3_q) lvl_q <= s3_q;
   end

   assign tick = s2_q & s3_q & ~lvl_q;
   assign per  = duty_i[1] ? 7'(lcdmdc_pkg::SLOT_SRC_8 - 1)
                           : 7'(lcdmdc_pkg::SLOT_SRC_16 - 1); // RULE20
   assign last = duty_i[1] ? lcdmdc_pkg::LAST_COM_8
               : (duty_i[0] ? lcdmdc_pkg::LAST_COM_16 : lcdmdc_pkg::LAST_COM_17); // RULE5

   // Slot divider and ascending common index
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q     <= 7'h00;
         com_idx_o <= 5'h00;
         phase_o   <= 1'b0;
      end else if (com_idx_o > last) begin
         div_q     <= 7'h00;
         com_idx_o <= 5'h00;
      end else if (tick) begin
         if (div_q >= per) begin
            div_q <= 7'h00;
            if (com_idx_o == last) begin
               com_idx_o <= 5'h00; // RULE21
               phase_o   <= ~phase_o;
            end else begin
               com_idx_o <= com_idx_o + 5'h01; // RULE21
            end
         end else begin
            div_q <= div_q + 7'h01;
         end
      end
   end

endmodule
`default_nettype wire

// File: src/lcdmdc_disp_mem.sv
`timescale 1ns/100ps
`default_nettype none
module lcdmdc_disp_mem #(
   parameter int SEG_N = 40
) (
   // Clock
   input  wire logic             clk_i,
   // Bus side
   input  wire logic             we_i,
   input  wire logic [7:0]       wslot_i,
   input  wire logic [3:0]       wdat_i,
   input  wire logic [7:0]       rslot_i,
   output logic [3:0]            rdat_o,
   // Scan side
   input  wire logic [4:0]       row_i,
   output logic [SEG_N-1:0]      row_o
);

   // Storage has no reset, contents start undefined
   logic [3:0] mem_q [lcdmdc_pkg::MEM_WORDS];

   // Bus write
   always_ff @(posedge clk_i) begin
      if (we_i) mem_q[wslot_i] <= wdat_i; // RULE19
   end

   assign rdat_o = mem_q[rslot_i];

   // One dot per segment for the selected row
   for (genvar s = 0; s < SEG_N; s++) begin : g_seg
      logic [7:0] w;
      assign w = row_i[4] ? lcdmdc_pkg::SLOT_ROW16 + 8'(s)
               : (row_i[3] ? lcdmdc_pkg::SLOT_PAGE1 : 8'h00) + 8'(2 * s) + 8'(row_i[2]);
      assign row_o[s] = row_i[4] ? mem_q[w][0] : mem_q[w][row_i[1:0]]; // RULE18
   end

endmodule
`default_nettype wire

// File: tb/lcdmdc_drive_props.sv
`timescale 1ns/100ps
`default_nettype none
module lcdmdc_drive_props #(
   parameter int SEG_N      = 40,
   parameter bit EXT_SUPPLY = 1'b0
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Bus
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [17:0]      wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   input  wire logic             wb_ack_o,
   // Panel and generator
   input  wire logic [16:0]      com_o,
   input  wire logic [SEG_N-1:0] seg_o,
   input  wire logic             frame_phase_o,
   input  wire logic             supply_on_o,
   input  wire logic             ref_mid_o,
   input  wire logic [3:0]       contrast_o
);
   logic [1:0] duty_q;
   logic       lit_q;
   logic       dark_q;

   // Shadow of committed control writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         duty_q <= 2'h0;
         lit_q  <= 1'b0;
         dark_q <= 1'b1;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]) begin
         if (wb_adr_i[17:2] == lcdmdc_pkg::IDX_DRIVE) begin
            duty_q <= wb_dat_i[3:2];
         end
         if (wb_adr_i[17:2] == lcdmdc_pkg::IDX_DISP) begin
            lit_q  <= wb_dat_i[1];
            dark_q <= wb_dat_i[2];
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Request and its one-cycle answer
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   chk_bus_answer:
      assert property (s_req |=> s_ack) else $error("ack not a single cycle pulse");
   chk_supply_blank:
      assert property (!supply_on_o && !$past(supply_on_o) |-> com_o == 17'h0
         && seg_o == '0 && !frame_phase_o) else $error("panel driven while supply off");
   chk_ref_gated:
      assert property ((EXT_SUPPLY || (!supply_on_o && !$past(supply_on_o)))
         |-> !ref_mid_o && contrast_o == 4'h0) else $error("generator control not gated");
   chk_com_onehot:
      assert property ($onehot0(com_o)) else $error("more than one common active");
   chk_com_ascend:
      assert property (supply_on_o && $past(com_o) != 17'h0 && com_o != 17'h0
         && com_o != $past(com_o) |-> com_o == ($past(com_o) << 1) || com_o == 17'h1)
         else $error("commons not ascending");
   chk_duty_eight:
      assert property (duty_q[1] && $past(duty_q[1], 4) |-> com_o[16:8] == 9'h0)
         else $error("common above 7 at eighth duty");
   chk_duty_sixteen:
      assert property (duty_q == 2'h1 && $past(duty_q, 4) == 2'h1 |-> !com_o[16])
         else $error("common 16 at sixteenth duty");
   chk_all_lit:
      assert property (lit_q && $past(lit_q, 4) && supply_on_o && $past(supply_on_o, 4)
         && com_o != 17'h0 |-> seg_o == {SEG_N{1'b1}}) else $error("all-lit not shown");
   chk_all_dark:
      assert property (dark_q && $past(dark_q, 4) && !lit_q && !$past(lit_q, 4)
         |-> seg_o == '0) else $error("all-dark not shown");
endmodule
`default_nettype wire

// File: tb/lcdmdc_panel_model.sv
`timescale 1ns/100ps
`default_nettype none
module lcdmdc_panel_model #(
   parameter int SEG_N = 40
) (
   // Clock and capture clear
   input  wire logic             clk_i,
   input  wire logic             clear_i,
   // Panel lines
   input  wire logic [16:0]      com_i,
   input  wire logic [SEG_N-1:0] seg_i,
   // Captured picture
   output logic [16:0]           seen_o,
   output logic [SEG_N-1:0]      rows_o [17]
);
   // Latch the dot row shown while each common is active
   always_ff @(posedge clk_i) begin
      if (clear_i) begin
         seen_o <= 17'h0;
      end else begin
         for (int c = 0; c < 17; c++) begin
            if (com_i == (17'h1 << c)) begin
               seen_o[c] <= 1'b1;
               rows_o[c] <= seg_i;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, osc_lo_i, clear_q;
   logic        frame_phase_o, supply_on_o, ref_mid_o;
   logic [17:0] wb_adr_i;
   logic [3:0]  wb_sel_i, contrast_o, d;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [16:0] com_o, seen;
   logic [39:0] seg_o;
   logic [39:0] rows [17];
   logic [3:0]  mem [int];
   logic [15:0] idx [3] = '{lcdmdc_pkg::IDX_DRIVE, lcdmdc_pkg::IDX_DISP, lcdmdc_pkg::IDX_CONTR};
   int          fails, checks, cyc_n, osc_n, n, a;

   lcdmdc_drive_top #(.SEG_N(40), .EXT_SUPPLY(1'b0)) u_dut (.*);
   lcdmdc_panel_model #(.SEG_N(40)) u_panel (.clk_i(clk_i), .clear_i(clear_q), .com_i(com_o),
      .seg_i(seg_o), .seen_o(seen), .rows_o(rows));

   // Clock, oscillator of 16 clocks, watchdog
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      osc_n <= (osc_n == 7) ? 0 : osc_n + 1;
      if (osc_n == 7) osc_lo_i <= ~osc_lo_i;
      cyc_n <= cyc_n + 1;
      if (cyc_n == 100000) begin
         fails++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (fails == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic single Wishbone cycle
   task automatic bus(input logic we, input logic [15:0] i, input logic [3:0] v);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {i, 2'($urandom)};
      wb_sel_i <= 4'hf;
      wb_dat_i <= {28'h0, v};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd_chk(input logic [15:0] i, input logic [3:0] e);
      bus(1'b0, i, 4'h0);
      check(rd, {28'h0, e});
   endtask
   task automatic clr();
      repeat (2) @(posedge clk_i); // Let control changes reach the panel
      clear_q <= 1'b1;
      @(posedge clk_i);
      clear_q <= 1'b0;
   endtask
   task automatic wait_frame(output int k);
      logic p;
      p = frame_phase_o;
      k = 0;
      while (frame_phase_o === p) begin
         @(negedge clk_i);
         k++;
      end
   endtask
   function automatic logic dot(int c, int s, logic pg);
      int b;
      if (c == 16) return mem[32'hf200 + 2 * s][0];
      b = (c > 7 || pg) ? 32'hf100 : 32'hf000;
      return mem[b + 2 * s + ((c & 7) >> 2)][c & 3];
   endfunction
   // Compare captured rows; mode 0 memory, 1 all lit, 2 all dark
   task automatic rows_chk(input logic pg, input int mode);
      logic [39:0] e;
      for (int c = 0; c < 17; c++) begin
         if (seen[c]) begin
            for (int s = 0; s < 40; s++) e[s] = (mode == 0) ? dot(c, s, pg) : (mode == 1);
            check(rows[c], e);
         end
      end
   endtask

   // Main sequence
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, osc_lo_i, clear_q} = '0;
      {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      {osc_n, cyc_n, fails, checks} = '0;
      rst_i = 1'b1;
      void'($urandom(92136));
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(lcdmdc_pkg::IDX_DRIVE, 4'h0);
      rd_chk(lcdmdc_pkg::IDX_DISP, 4'h4);
      rd_chk(16'hff70, 4'h0);
      rd_chk(lcdmdc_pkg::IDX_STATUS, 4'h0);
      check(com_o, 0);
      for (int k = 0; k < 12; k++) begin
         d = 4'($urandom);
         bus(1'b1, idx[k % 3], d);
         rd_chk(idx[k % 3], d);
      end
      // Populated memory only
      for (int s = 0; s < 40; s++) begin
         for (int k = 0; k < 5; k++) begin
            a = (k < 2 ? 32'hf000 : k < 4 ? 32'hf100 : 32'hf200) + 2 * s + (k < 4 ? k & 1 : 0);
            mem[a] = 4'($urandom);
            bus(1'b1, 16'(a), mem[a]);
         end
      end
      foreach (mem[i]) rd_chk(16'(i), mem[i]);
      bus(1'b1, lcdmdc_pkg::IDX_CONTR, 4'h7);
      bus(1'b1, lcdmdc_pkg::IDX_DISP, 4'h0);
      bus(1'b1, lcdmdc_pkg::IDX_DRIVE, 4'h3);
      repeat (20) @(posedge clk_i);
      check({supply_on_o, ref_mid_o, contrast_o}, 6'h37);
      clr();
      wait_frame(n);
      wait_frame(n);
      check(n, 1088 * 16);
      check(seen, 17'h1ffff);
      rows_chk(1'b0, 0);
      bus(1'b1, lcdmdc_pkg::IDX_DRIVE, 4'h7);
      clr();
      repeat (17000) @(posedge clk_i);
      check(seen, 17'h0ffff);
      bus(1'b1, lcdmdc_pkg::IDX_DISP, 4'h1);
      bus(1'b1, lcdmdc_pkg::IDX_DRIVE, 4'hf);
      clr();
      repeat (17000) @(posedge clk_i);
      check(seen, 17'h000ff);
      rows_chk(1'b1, 0);
      for (int k = 1; k < 4; k++) begin
         bus(1'b1, lcdmdc_pkg::IDX_DISP, 4'(2 * k));
         clr();
         repeat (3000) @(posedge clk_i);
         rows_chk(1'b0, k == 2 ? 2 : 1);
      end
      rd_chk(16'hf000, mem[32'hf000]);
      bus(1'b1, lcdmdc_pkg::IDX_DRIVE, 4'h0);
      repeat (5) @(posedge clk_i);
      check({com_o, seg_o, frame_phase_o, supply_on_o, ref_mid_o, contrast_o}, 0);
      report_and_stop();
   end
endmodule

bind lcdmdc_drive_top lcdmdc_drive_props #(.SEG_N(SEG_N), .EXT_SUPPLY(EXT_SUPPLY)) u_props (.*);
`default_nettype wire
